// file: cac_top.sv
`timescale 1ns/100ps
`include "cac_cfg.svh"

// Overview of operation
// - counter rollover sets overflow flag, bit 7 of counter_array_control.
// - overflow flag requests interrupt only while overflow_irq_enable is set.
// - overflow flag set by hardware or software; only software clears it.
// - run bit 6 set by software starts counter; cleared stops it.
// - five module event flags, bits 4..0, set on match or capture.
// - bit 5 reserved, reads undefined; software never writes one there.
// - reset clears defined bits; register accessed only as whole byte.
// - counter_array_control decoded at address d8h.
// - only module 4 is the watchdog, sharing its match and flag.
// - compare match interrupts only when module flag and its enable set.
// - watchdog match makes internal reset, never drives external reset pin.
module cac_top (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire cac_pkg::cac_wb_req_t wb_req_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 counter_rollover_i,
    input  wire logic [4:0]           module_event_i,
    output logic                      counter_run_o,
    output logic                      irq_o,
    output logic                      internal_reset_o
);
    import cac_pkg::*;

    // reset image of the control byte; only the run bit is taken from it below
    localparam logic [7:0] CTRL_RST = `CAC_CTRL_RST;

    cac_bus_state_t            bus_state_reg;
    cac_bus_state_t            bus_state_next;
    logic                      req_live;
    logic                      req_take;
    logic                      wr_ctrl;
    logic                      wr_ien;
    logic [`CAC_IEN_W-1:0]     ien_reg;
    logic [`CAC_NMOD:0]        flag_set;
    logic [`CAC_NMOD:0]        flag_wdata;
    logic [`CAC_NMOD:0]        flag_q;
    logic [`CAC_NMOD-1:0]      module_event_flag;
    logic                      counter_overflow_flag;
    logic                      overflow_irq_enable;
    logic [`CAC_NMOD-1:0]      module_irq_enable;
    logic                      wdt_enable;
    logic                      irq_cond;
    logic [7:0]                ctrl_view;
    logic [31:0]               rd_next;

    // byte-wide register hit; any other lane pattern is not a hit
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [3:0] sel,
                                     input logic [7:0] target);
        reg_hit = (adr == target) && (sel == `CAC_SEL_BYTE);
    endfunction

    // request present; taken at the edge where ack is high
    assign req_live = wb_req_i.cyc && wb_req_i.stb;
    assign req_take = req_live && (bus_state_reg == CAC_BUS_ACK);
    assign wr_ctrl  = req_take && wb_req_i.we
                      && reg_hit(wb_req_i.adr, wb_req_i.sel,
                                 `CAC_CTRL_ADDR);
    assign wr_ien   = req_take && wb_req_i.we
                      && reg_hit(wb_req_i.adr, wb_req_i.sel,
                                 `CAC_IEN_ADDR);

    // bus answer sequencing: one wait, one ack cycle
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            CAC_BUS_IDLE: begin
                if (req_live) begin
                    bus_state_next = CAC_BUS_ACK;
                end
            end
            CAC_BUS_ACK: begin
                bus_state_next = CAC_BUS_IDLE;
            end
            default: begin
                bus_state_next = CAC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_reg <= CAC_BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // ack straight from the flop so the output is registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= (bus_state_next == CAC_BUS_ACK);
        end
    end

    // hardware set sources and software write data per flag
    assign flag_set   = {counter_rollover_i, module_event_i};
    assign flag_wdata = {wb_req_i.dat[`CAC_CF_BIT],
                         wb_req_i.dat[`CAC_NMOD-1:0]};

    // one sticky cell per flag; module 4 cell doubles as watchdog flag
    genvar gi;
    generate
        for (gi = 0; gi <= `CAC_NMOD; gi++) begin : g_flag
            cac_flag u_flag (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .set_i   (flag_set[gi]),
                .wr_i    (wr_ctrl),
                .wdata_i (flag_wdata[gi]),
                .flag_o  (flag_q[gi])
            );
        end
    endgenerate

    assign module_event_flag     = flag_q[`CAC_NMOD-1:0];
    assign counter_overflow_flag = flag_q[`CAC_NMOD];

    // run bit gates the shared counter outside this block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_run_o <= CTRL_RST[`CAC_RUN_BIT];
        end else if (wr_ctrl) begin
            counter_run_o <= wb_req_i.dat[`CAC_RUN_BIT];
        end
    end

    // interrupt and watchdog enables, a register of their own
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien_reg <= `CAC_IEN_RST;
        end else if (wr_ien) begin
            ien_reg <= wb_req_i.dat[`CAC_IEN_W-1:0];
        end
    end

    assign overflow_irq_enable = ien_reg[`CAC_ECF_BIT];
    assign module_irq_enable   =
        ien_reg[`CAC_EMOD_LSB +: `CAC_NMOD];
    assign wdt_enable          = ien_reg[`CAC_WDT_EN_BIT];

    // interrupt request from enabled flags
    assign irq_cond =
        (counter_overflow_flag && overflow_irq_enable)
        || |(module_event_flag & module_irq_enable);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_cond;
        end
    end

    // watchdog reset is an internal pulse, no pin drive at all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            internal_reset_o <= 1'b0;
        end else begin
            internal_reset_o <= wdt_enable
                                && module_event_i[`CAC_NMOD-1];
        end
    end

    // reserved bit reads zero, a safe pick for undefined
    always_comb begin
        ctrl_view                  = 8'h00;
        ctrl_view[`CAC_CF_BIT]     = counter_overflow_flag;
        ctrl_view[`CAC_RUN_BIT]    = counter_run_o;
        ctrl_view[`CAC_RSV_BIT]    = 1'b0;
        ctrl_view[`CAC_NMOD-1:0]   = module_event_flag;
    end

    // read mux; unmapped addresses read zero and still ack
    always_comb begin
        rd_next = 32'h0000_0000;
        if (reg_hit(wb_req_i.adr, wb_req_i.sel, `CAC_CTRL_ADDR)) begin
            rd_next[7:0] = ctrl_view;
        end else if (reg_hit(wb_req_i.adr, wb_req_i.sel,
                             `CAC_IEN_ADDR)) begin
            rd_next[`CAC_IEN_W-1:0] = ien_reg;
        end
    end

    // data latched with ack so it stands stable while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_state_next == CAC_BUS_ACK) begin
            wb_dat_o <= rd_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    cf_set_a: assert property (
        counter_rollover_i |=> counter_overflow_flag)
        else $error("overflow flag not set on rollover");

    cf_hold_a: assert property (
        counter_overflow_flag && !wr_ctrl |=> counter_overflow_flag)
        else $error("overflow flag lost without write");

    irq_cf_a: assert property (
        counter_overflow_flag && overflow_irq_enable
        && $stable(counter_overflow_flag) |=> irq_o)
        else $error("enabled overflow gave no interrupt");

    irq_quiet_a: assert property (
        !overflow_irq_enable
        && ((module_event_flag & module_irq_enable) == 5'h00)
        |=> !irq_o)
        else $error("interrupt without enabled flag");

    run_write_a: assert property (
        wr_ctrl |=> counter_run_o == $past(wb_req_i.dat[6]))
        else $error("run bit did not take written value");

    run_hold_a: assert property (
        !wr_ctrl |=> $stable(counter_run_o))
        else $error("run bit changed without write");

    mod_set_a: assert property (
        |module_event_i |=> ((module_event_flag & $past(module_event_i))
                             == $past(module_event_i)))
        else $error("module event flag not set");

    mod_hold_a: assert property (
        !wr_ctrl |=> ((module_event_flag & $past(module_event_flag))
                      == $past(module_event_flag)))
        else $error("module flag cleared by hardware");

    set_wins_a: assert property (
        module_event_i[0] && wr_ctrl && !wb_req_i.dat[0]
        |=> module_event_flag[0])
        else $error("clear beat a same-cycle event");

    rsv_zero_a: assert property (
        wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000)
                     && !(wb_dat_o[5] && $past(wb_req_i.adr) == 8'hd8))
        else $error("reserved or upper bits read nonzero");

    wdt_rst_a: assert property (
        wdt_enable && module_event_i[`CAC_NMOD-1] |=> internal_reset_o)
        else $error("watchdog match gave no reset pulse");

    wdt_quiet_a: assert property (
        !(wdt_enable && module_event_i[`CAC_NMOD-1]) |=> !internal_reset_o)
        else $error("internal reset without watchdog match");

    cf_clear_a: assert property (
        wr_ctrl && !wb_req_i.dat[`CAC_CF_BIT] && !counter_rollover_i
        |=> !counter_overflow_flag)
        else $error("overflow flag not cleared by write");

    cf_sw_set_a: assert property (
        wr_ctrl && wb_req_i.dat[`CAC_CF_BIT] |=> counter_overflow_flag)
        else $error("overflow flag not set by write");

    irq_mod_a: assert property (
        |(module_event_flag & module_irq_enable) |=> irq_o)
        else $error("enabled module flag gave no interrupt");

    ack_req_a: assert property (
        wb_ack_o |-> $past(req_live))
        else $error("ack without a request");

    ack_pulse_a: assert property (
        req_live && !wb_ack_o && bus_state_reg == CAC_BUS_IDLE
        |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");

    // reset itself is the trigger, so the default disable must not apply
    reset_clear_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> (flag_q == 6'h00) && !counter_run_o && !irq_o
                  && !internal_reset_o && !wb_ack_o)
        else $error("reset left state set");

    cf_set_c:  cover property (counter_rollover_i ##1 irq_o);
    wdt_c:     cover property (internal_reset_o);
    clear_c:   cover property (module_event_flag[0] ##1 wr_ctrl
                               ##1 !module_event_flag[0]);
    run_c:     cover property (wr_ctrl ##1 counter_run_o);

endmodule // cac_top

// file: cac_cfg.svh
`ifndef CAC_CFG_SVH
`define CAC_CFG_SVH

// register byte addresses on the wishbone bus
`define CAC_CTRL_ADDR     8'hd8
`define CAC_IEN_ADDR      8'hdc

// counter_array_control field positions
`define CAC_CF_BIT        7
`define CAC_RUN_BIT       6
`define CAC_RSV_BIT       5
`define CAC_NMOD          5

// irq enable register field positions
`define CAC_ECF_BIT       0
`define CAC_EMOD_LSB      1
`define CAC_WDT_EN_BIT    6
`define CAC_IEN_W         7

// reset values
`define CAC_CTRL_RST      8'h00
`define CAC_IEN_RST       7'h00

// only byte lane 0 carries a register
`define CAC_SEL_BYTE      4'h1

`endif

// file: cac_pkg.sv
package cac_pkg;

    // one classic wishbone request as seen by the slave
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } cac_wb_req_t;

    // bus answer state, one-hot
    typedef enum logic [1:0] {
        CAC_BUS_IDLE = 2'b01,
        CAC_BUS_ACK  = 2'b10
    } cac_bus_state_t;

endpackage

// file: cac_flag.sv
`timescale 1ns/100ps

// sticky flag: hardware set beats a same-cycle software write
module cac_flag (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic wr_i,
    input  wire logic wdata_i,
    output logic      flag_o
);

    // set first so an event in the clearing cycle survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (wr_i) begin
            flag_o <= wdata_i;
        end
    end

endmodule // cac_flag

// file: tb.sv
`timescale 1ns/100ps

module tb;
    import cac_pkg::*;

    logic                 clk_i;
    logic                 rst_i;
    cac_wb_req_t          req;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    logic                 roll;
    logic [4:0]           mev;
    logic                 counter_run_o;
    logic                 irq_o;
    logic                 internal_reset_o;
    logic [31:0]          rd;
    int                   errors;
    int                   cmp_count;

    cac_top dut (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .wb_req_i           (req),
        .wb_dat_o           (wb_dat_o),
        .wb_ack_o           (wb_ack_o),
        .counter_rollover_i (roll),
        .module_event_i     (mev),
        .counter_run_o      (counter_run_o),
        .irq_o              (irq_o),
        .internal_reset_o   (internal_reset_o)
    );

    // 250 mhz core clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic tally_and_finish;
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    // classic single cycle; ev pulses once, into the edge that sees ack
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [7:0] d, input logic [4:0] ev,
                       input logic [3:0] s);
        int n;
        n = 1;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s,
                 dat: {24'h0, d}};
        @(posedge clk_i);
        mev <= ev;
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 50) errors++;
        rd = wb_dat_o;
        req <= '0;
        mev <= 5'h00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 5'h00, 4'h1);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [7:0] e);
        bus(1'b0, a, 8'h00, 5'h00, 4'h1);
        chk(nm, {24'h0, e}, rd);
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic t_reset_and_run;
        rdchk("ctrl reset", 8'hd8, 8'h00);
        rdchk("ien reset", 8'hdc, 8'h00);
        wr(8'hd8, 8'h40);
        settle();
        chk("run on", 1, counter_run_o);
        rdchk("run readback", 8'hd8, 8'h40);
        wr(8'hd8, 8'h00);
        settle();
        chk("run off", 0, counter_run_o);
        // reserved bit never stores, odd address decodes nothing
        wr(8'hd8, 8'h20);
        rdchk("reserved bit", 8'hd8, 8'h00);
        wr(8'hd9, 8'h40);
        settle();
        chk("unmapped write", 0, counter_run_o);
        rdchk("unmapped read", 8'hd9, 8'h00);
        // a write on the wrong byte lane must not reach the register
        bus(1'b1, 8'hd8, 8'h40, 5'h00, 4'h2);
        settle();
        chk("lane write", 0, counter_run_o);
    endtask

    // reset in mid-run wipes the run bit again; no flag is set before it
    task automatic t_mid_reset;
        wr(8'hd8, 8'h40);
        wr(8'hd8, 8'h40);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("run after reset", 0, counter_run_o);
        rdchk("ctrl after reset", 8'hd8, 8'h00);
        rdchk("ien after reset", 8'hdc, 8'h00);
    endtask

    task automatic t_overflow;
        wr(8'hdc, 8'h01);
        @(posedge clk_i);
        roll <= 1'b1;
        @(posedge clk_i);
        roll <= 1'b0;
        settle();
        chk("irq overflow", 1, irq_o);
        rdchk("overflow flag", 8'hd8, 8'h80);
        wr(8'hdc, 8'h00);
        settle();
        chk("irq masked", 0, irq_o);
        rdchk("flag kept", 8'hd8, 8'h80);
        wr(8'hd8, 8'h00);
        rdchk("flag cleared", 8'hd8, 8'h00);
        wr(8'hd8, 8'h80);
        rdchk("flag sw set", 8'hd8, 8'h80);
        wr(8'hd8, 8'h00);
    endtask

    task automatic t_modules;
        for (int n = 0; n < 5; n++) begin
            @(posedge clk_i);
            mev <= 5'h01 << n;
            @(posedge clk_i);
            mev <= 5'h00;
            repeat (10) @(posedge clk_i);
            chk("irq disabled", 0, irq_o);
            rdchk("module flag", 8'hd8, 8'h01 << n);
            wr(8'hdc, 8'h02 << n);
            settle();
            chk("module irq", 1, irq_o);
            wr(8'hd8, 8'h00);
            settle();
            chk("irq after clear", 0, irq_o);
            wr(8'hdc, 8'h00);
        end
        // hardware set lands on the edge of a clearing write
        wr(8'hd8, 8'h04);
        bus(1'b1, 8'hd8, 8'h00, 5'h02, 4'h1);
        rdchk("set beats clear", 8'hd8, 8'h02);
        wr(8'hd8, 8'h00);
    endtask

    task automatic wdt_count(input logic [7:0] en, input int e);
        int c;
        c = 0;
        wr(8'hdc, en);
        @(posedge clk_i);
        mev <= 5'h10;
        @(posedge clk_i);
        mev <= 5'h00;
        repeat (6) begin
            @(posedge clk_i);
            if (internal_reset_o === 1'b1) c++;
        end
        chk("internal reset pulses", e, c);
        rdchk("module4 flag", 8'hd8, 8'h10);
        wr(8'hd8, 8'h00);
    endtask

    // watchdog hang guard, far beyond the expected run time
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        tally_and_finish();
    end

    initial begin
        errors = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        req = '0;
        roll = 1'b0;
        mev = 5'h00;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("irq at reset", 0, irq_o);
        t_reset_and_run();
        t_overflow();
        t_mid_reset();
        t_modules();
        wdt_count(8'h00, 0);
        wdt_count(8'h40, 1);
        tally_and_finish();
    end
endmodule // tb
